// >>> rtl/csr_pkg.sv
// Constants and carrier types for the core special register block
// ----------------------------------------------------------------
// Summary of operation
// - Page bit picks program page 0 (000-3FF) or page 1 (400-7FF).
// - Eleven-bit program counter cleared by power-on and watchdog reset.
// - Timer, pattern and port-5 interrupts fetch from the general vector.
// - Endpoint-zero, suspend, bus reset, resume interrupts use the USB vector.
// - 112 bytes of general data RAM, apart from FIFOs and special registers.
// - Operation registers 0x00-0x0E in bank 0, 0x08-0x0F in bank 1.
// - Control registers 0x05-0x0F in bank 0, 0x08-0x0F in bank 1.
// - Control registers reached only by the control read and write ops.
// - Bank bit set maps bank-1 registers at 8-F, clear maps bank 0 at 5-E, or 5-F for control registers.
// - Indirect port is not stored; it accesses RAM at the select pointer.
// - Eight-bit timer register, read/write, zeroed by both resets.
// - Carry bit 0, aux carry bit 1, zero flag bit 2 set on zero result.
// - Power-down flag set by power-on and clear op, cleared entering sleep.
// - Time-out flag set by power-on and clear op, cleared on watchdog overflow.
// - After sleep or port-change wake, time-out stays 1, power-down 0.
// - Status bit 6 is plain storage with no side effect.
// - Serial pattern pin is input only and feeds the pattern detector.
// - Firmware picks USB or PS/2 role for each data-line pin.
// - A data line in PS/2 role raises an interrupt on each state change.
// - Pointer low six bits 0x00-0x1F are common in every bank; from 0x20, the top two bits pick a bank.
// ----------------------------------------------------------------
package csr_pkg;
	localparam logic [5:0] ADR_INDIRECT = 6'h00;
	localparam logic [5:0] ADR_TIMER = 6'h01;
	localparam logic [5:0] ADR_PC_LOW = 6'h02;
	localparam logic [5:0] ADR_STATUS = 6'h03;
	localparam logic [5:0] ADR_RAM_SEL = 6'h04;
	localparam logic [5:0] ADR_SOP_B0_LAST = 6'h0e;
	localparam logic [5:0] ADR_CTL_B0_FIRST = 6'h05;
	localparam logic [5:0] ADR_B1_FIRST = 6'h08;
	localparam logic [5:0] ADR_SPEC_LAST = 6'h0f;
	localparam logic [5:0] ADR_COMMON_FIRST = 6'h10;
	localparam logic [5:0] ADR_BANKED_FIRST = 6'h20;
	localparam logic [1:0] RAM_BANKS_BUILT = 2'h3;
	localparam logic [6:0] RAM_COMMON_SIZE = 7'h10;
	localparam logic [6:0] RAM_BANK_SIZE = 7'h20;
	localparam int RAM_BYTES = 112;
	localparam int ST_C = 0;
	localparam int ST_DC = 1;
	localparam int ST_Z = 2;
	localparam int ST_P = 3;
	localparam int ST_T = 4;
	localparam int ST_PAGE = 5;
	localparam int ST_GP = 6;
	localparam int ST_BANK = 7;
	localparam logic [7:0] STATUS_RST = 8'h18;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [10:0] PC_RST = 11'h000;
	localparam logic [10:0] VEC_GENERAL = 11'h001;
	localparam logic [10:0] VEC_USB = 11'h00a;
	localparam logic [10:0] PC_ONE = 11'h001;
	localparam logic [7:0] TIMER_ONE = 8'h01;
	localparam logic [7:0] TIMER_MAX = 8'hff;

	typedef struct packed {
		logic rd;
		logic wr;
		logic ctl;
		logic [5:0] addr;
		logic [7:0] wdata;
	} csr_req_t;

	typedef struct packed {
		logic stb;
		logic wr;
		logic ctl;
		logic bank1;
		logic [3:0] addr;
		logic [7:0] wdata;
	} csr_ext_t;
endpackage : csr_pkg

// >>> rtl/csr_core_regs.sv
// Core special registers: counter, status, timer, RAM, pin roles
`timescale 1ns/1ps
module csr_core_regs
	import csr_pkg::*;
#(
	parameter int LINES = 2
)
(
	// Clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic wdt_rst,
	// Register access from the instruction unit
	input wire csr_req_t req,
	output csr_ext_t ext_ff,
	output logic rsp_valid_ff,
	output logic rsp_ext_ff,
	output logic [7:0] rdata_ff,
	// Program flow
	input wire logic pc_inc,
	input wire logic jump,
	input wire logic [9:0] jump_tgt,
	input wire logic irq_general,
	input wire logic irq_usb,
	output logic [10:0] pc_ff,
	// Arithmetic flags and power events
	input wire logic alu_upd,
	input wire logic alu_c,
	input wire logic alu_dc,
	input wire logic alu_z,
	input wire logic wdt_clear_op,
	input wire logic sleep_enter,
	input wire logic wdt_timeout,
	output logic [7:0] status_flags_ff,
	// Timer
	input wire logic timer_tick,
	output logic timer_ovf_ff,
	// Pins
	input wire logic serial_pattern_input_pin,
	output logic pattern_serial_ff,
	input wire logic [LINES-1:0] line_ps2_mode,
	input wire logic [LINES-1:0] line_in,
	output logic [LINES-1:0] line_usb_role_ff,
	output logic [LINES-1:0] line_chg_irq_ff
);
	initial
	begin
		if (LINES != 2)
			$error("csr_core_regs: exactly two data lines supported");
	end

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	logic [7:0] timer_count_value_ff, nxt_timer;
	logic [7:0] ram_select_pointer_ff, nxt_rsel;
	logic [7:0] nxt_status;
	logic [10:0] nxt_pc;
	logic nxt_ovf;
	logic [7:0] ram [RAM_BYTES];
	logic [5:0] eff_addr;
	logic [1:0] eff_bank;
	logic [6:0] ram_idx;
	logic ram_hit, is_local, spec_hit;
	logic bank1;

	// Indirect port resolves to the pointer, never to itself
	always_comb
	begin
		eff_addr = req.addr;
		eff_bank = ram_select_pointer_ff[7:6];
		if (!req.ctl && req.addr == ADR_INDIRECT)
			eff_addr = ram_select_pointer_ff[5:0];
	end

	always_comb
	begin
		ram_idx = 7'h00;
		ram_hit = 1'b0;
		if (req.ctl)
		begin
			ram_hit = 1'b0;
		end
		else if (eff_addr >= ADR_BANKED_FIRST)
		begin
			ram_hit = (eff_bank < RAM_BANKS_BUILT);
			ram_idx = RAM_COMMON_SIZE + 7'(eff_bank) * RAM_BANK_SIZE
				+ 7'(eff_addr - ADR_BANKED_FIRST);
		end
		else if (eff_addr >= ADR_COMMON_FIRST)
		begin
			ram_hit = 1'b1;
			ram_idx = 7'(eff_addr - ADR_COMMON_FIRST);
		end
	end

	// Low bank-0 registers stay visible whatever the bank bit says
	always_comb
	begin
		// Bank 1 covers only 08-0F, never the RAM space above it
		bank1 = status_flags_ff[ST_BANK] && eff_addr >= ADR_B1_FIRST
			&& eff_addr <= ADR_SPEC_LAST;
		is_local = !req.ctl && eff_addr >= ADR_TIMER
			&& eff_addr <= ADR_RAM_SEL;
		spec_hit = 1'b0;
		if (req.ctl)
		begin
			if (eff_addr >= ADR_CTL_B0_FIRST && eff_addr <= ADR_SPEC_LAST)
				spec_hit = 1'b1;
		end
		else if (bank1)
			spec_hit = 1'b1;
		else if (eff_addr > ADR_RAM_SEL && eff_addr <= ADR_SOP_B0_LAST)
			spec_hit = 1'b1;
	end

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic wr_loc;
	assign wr_loc = req.wr && is_local;

	always_comb
	begin
		nxt_timer = timer_count_value_ff;
		nxt_ovf = 1'b0;
		if (wr_loc && eff_addr == ADR_TIMER)
			nxt_timer = req.wdata;
		else if (timer_tick)
		begin
			nxt_timer = timer_count_value_ff + TIMER_ONE;
			nxt_ovf = (timer_count_value_ff == TIMER_MAX);
		end
		if (wdt_rst)
		begin
			nxt_timer = BYTE_ZERO;
			nxt_ovf = 1'b0;
		end
	end

	always_comb
	begin
		nxt_rsel = ram_select_pointer_ff;
		if (wr_loc && eff_addr == ADR_RAM_SEL)
			nxt_rsel = req.wdata;
	end

	// Flag events beat a software write in the same cycle
	always_comb
	begin
		nxt_status = status_flags_ff;
		if (wr_loc && eff_addr == ADR_STATUS)
		begin
			nxt_status = req.wdata;
			nxt_status[ST_T] = status_flags_ff[ST_T];
			nxt_status[ST_P] = status_flags_ff[ST_P];
		end
		if (alu_upd)
		begin
			nxt_status[ST_C] = alu_c;
			nxt_status[ST_DC] = alu_dc;
			nxt_status[ST_Z] = alu_z;
		end
		if (sleep_enter)
		begin
			nxt_status[ST_P] = 1'b0;
			nxt_status[ST_T] = 1'b1;
		end
		if (wdt_clear_op)
		begin
			nxt_status[ST_P] = 1'b1;
			nxt_status[ST_T] = 1'b1;
		end
		if (wdt_rst)
			nxt_status = status_flags_ff & (8'h01 << ST_P | 8'h01 << ST_T);
		if (wdt_timeout)
			nxt_status[ST_T] = 1'b0;
	end

	always_comb
	begin
		nxt_pc = pc_ff;
		if (irq_usb)
			nxt_pc = VEC_USB;
		else if (irq_general)
			nxt_pc = VEC_GENERAL;
		else if (jump)
			nxt_pc = {status_flags_ff[ST_PAGE], jump_tgt};
		else if (wr_loc && eff_addr == ADR_PC_LOW)
			nxt_pc = {status_flags_ff[ST_PAGE], 2'b00, req.wdata};
		else if (pc_inc)
			nxt_pc = pc_ff + PC_ONE;
		if (wdt_rst)
			nxt_pc = PC_RST;
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			timer_count_value_ff <= BYTE_ZERO;
			timer_ovf_ff <= 1'b0;
			ram_select_pointer_ff <= BYTE_ZERO;
			status_flags_ff <= STATUS_RST;
			pc_ff <= PC_RST;
		end
		else
		begin
			timer_count_value_ff <= nxt_timer;
			timer_ovf_ff <= nxt_ovf;
			ram_select_pointer_ff <= nxt_rsel;
			status_flags_ff <= nxt_status;
			pc_ff <= nxt_pc;
		end
	end

	// Data RAM keeps no reset, as real SRAM would
	always_ff @(posedge mclk)
	begin
		if (req.wr && ram_hit)
			ram[ram_idx] <= req.wdata;
	end

	// ----------------------------------------------------------------
	// Access answer
	// ----------------------------------------------------------------
	csr_ext_t nxt_ext;
	logic [7:0] nxt_rdata;
	logic nxt_rsp, nxt_rsp_ext;

	always_comb
	begin
		nxt_ext = '0;
		nxt_ext.stb = (req.rd || req.wr) && spec_hit;
		nxt_ext.wr = req.wr;
		nxt_ext.ctl = req.ctl;
		nxt_ext.bank1 = bank1;
		nxt_ext.addr = eff_addr[3:0];
		nxt_ext.wdata = req.wdata;
		nxt_rsp = req.rd;
		nxt_rsp_ext = req.rd && spec_hit;
		nxt_rdata = BYTE_ZERO;
		if (req.rd && ram_hit)
			nxt_rdata = ram[ram_idx];
		else if (req.rd && is_local)
		begin
			case (eff_addr)
				ADR_TIMER: nxt_rdata = timer_count_value_ff;
				ADR_PC_LOW: nxt_rdata = pc_ff[7:0];
				ADR_STATUS: nxt_rdata = status_flags_ff;
				default: nxt_rdata = ram_select_pointer_ff;
			endcase
		end
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ext_ff <= '0;
			rsp_valid_ff <= 1'b0;
			rsp_ext_ff <= 1'b0;
			rdata_ff <= BYTE_ZERO;
		end
		else
		begin
			ext_ff <= nxt_ext;
			rsp_valid_ff <= nxt_rsp;
			rsp_ext_ff <= nxt_rsp_ext;
			rdata_ff <= nxt_rdata;
		end
	end

	// ----------------------------------------------------------------
	// Pin roles
	// ----------------------------------------------------------------
	// Pattern pin has no driver at all, so no enable exists
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			pattern_serial_ff <= 1'b0;
		else
			pattern_serial_ff <= serial_pattern_input_pin;
	end

	// One register process writes all three vectors, so each output has a single writer
	logic [LINES-1:0] prev_ff, nxt_prev, nxt_chg;
	assign nxt_prev = line_in;

	genvar gi;
	generate
		for (gi = 0; gi < LINES; gi++)
		begin : g_line
			assign nxt_chg[gi] = line_ps2_mode[gi]
				&& (line_in[gi] != prev_ff[gi]);
		end
	endgenerate

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			prev_ff <= '0;
			line_chg_irq_ff <= '0;
			line_usb_role_ff <= '1;
		end
		else
		begin
			prev_ff <= nxt_prev;
			line_chg_irq_ff <= nxt_chg;
			line_usb_role_ff <= ~line_ps2_mode;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_wdt_pc_clear: assert property (@(posedge mclk) disable iff (sys_rst)
		wdt_rst |=> pc_ff == PC_RST) else $error("pc not cleared");
	a_usb_vector: assert property (@(posedge mclk) disable iff (sys_rst)
		irq_usb && !wdt_rst |=> pc_ff == VEC_USB) else $error("usb vector");
	a_gen_vector: assert property (@(posedge mclk) disable iff (sys_rst)
		irq_general && !irq_usb && !wdt_rst |=> pc_ff == VEC_GENERAL)
		else $error("general vector");
	a_jump_page: assert property (@(posedge mclk) disable iff (sys_rst)
		jump && !irq_usb && !irq_general && !wdt_rst
		|=> pc_ff[10] == $past(status_flags_ff[ST_PAGE]))
		else $error("jump page");
	a_timeout_flag: assert property (@(posedge mclk) disable iff (sys_rst)
		wdt_timeout |=> !status_flags_ff[ST_T]) else $error("time-out flag");
	a_sleep_flags: assert property (@(posedge mclk) disable iff (sys_rst)
		sleep_enter && !wdt_clear_op && !wdt_rst && !wdt_timeout
		|=> status_flags_ff[ST_T] && !status_flags_ff[ST_P])
		else $error("sleep flags");
	a_line_change: assert property (@(posedge mclk) disable iff (sys_rst)
		line_ps2_mode[0] && $changed(line_in[0]) |=> line_chg_irq_ff[0])
		else $error("line change lost");
	a_ctl_only_op: assert property (@(posedge mclk) disable iff (sys_rst)
		req.ctl && req.rd |=> rdata_ff == BYTE_ZERO) else $error("ctl path");
	a_timer_reset: assert property (@(posedge mclk) disable iff (sys_rst)
		wdt_rst |=> timer_count_value_ff == BYTE_ZERO ##1 1'b1)
		else $error("timer reset");
endmodule : csr_core_regs

// >>> rtl/unused_placeholder_removed.sv
// Intentionally empty compile unit
`timescale 1ns/1ps

// >>> bench/tb_csr_core_regs.sv
// Self-checking bench for the core special register block
`timescale 1ns/1ps
module tb_csr_core_regs;
	import csr_pkg::*;
	localparam logic [2:0] RD = 3'h4;
	localparam logic [2:0] WR = 3'h2;
	localparam logic [2:0] CRD = 3'h5;
	localparam logic [2:0] CWR = 3'h3;
	logic mclk;
	logic sys_rst;
	csr_req_t req;
	csr_ext_t ext;
	csr_ext_t ge;
	logic [9:0] ev;
	logic [2:0] alu_f;
	logic [9:0] tgt;
	logic pin;
	logic [1:0] ps2;
	logic [1:0] lin;
	logic [1:0] irq;
	logic [1:0] role;
	logic [1:0] lirq;
	logic rv;
	logic rx;
	logic gv;
	logic gx;
	logic tovf;
	logic pser;
	logic s;
	logic [7:0] rd;
	logic [7:0] st;
	logic [7:0] gd;
	logic [7:0] gt;
	logic [7:0] ex;
	logic [10:0] pc;
	int n_errors = 0;
	int total_checks = 0;
	int cyc = 0;

	csr_core_regs #(.LINES(2)) i_csr_core_regs (
		.mclk(mclk), .sys_rst(sys_rst), .wdt_rst(ev[9]), .req(req),
		.ext_ff(ext), .rsp_valid_ff(rv), .rsp_ext_ff(rx), .rdata_ff(rd),
		.pc_inc(ev[0]), .jump(ev[1]), .jump_tgt(tgt),
		.irq_general(ev[2]), .irq_usb(ev[3]), .pc_ff(pc),
		.alu_upd(ev[4]), .alu_c(alu_f[0]), .alu_dc(alu_f[1]),
		.alu_z(alu_f[2]), .wdt_clear_op(ev[5]), .sleep_enter(ev[6]),
		.wdt_timeout(ev[7]), .status_flags_ff(st), .timer_tick(ev[8]),
		.timer_ovf_ff(tovf), .serial_pattern_input_pin(pin),
		.pattern_serial_ff(pser), .line_ps2_mode(ps2), .line_in(lin),
		.line_usb_role_ff(role), .line_chg_irq_ff(lirq));

	initial
	begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	// --------------------
	// Access and event tasks
	// --------------------
	task automatic chk(input logic [10:0] g, input logic [10:0] e);
		total_checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk

	// Request held one cycle, answer sampled once the taking edge settles
	task automatic acc(input logic [2:0] op, input logic [5:0] a,
		input logic [7:0] d);
		@(posedge mclk);
		req <= '{op[2], op[1], op[0], a, d};
		@(posedge mclk);
		req <= '0;
		#1;
		gd = rd;
		gv = rv;
		gx = rx;
		ge = ext;
	endtask : acc

	task automatic fire(input logic [9:0] e);
		@(posedge mclk);
		ev <= e;
		@(posedge mclk);
		ev <= '0;
		#1;
	endtask : fire

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : report_and_stop

	// Whole run needs well under a thousand cycles
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			n_errors++;
			report_and_stop();
		end
	end

	// --------------------
	// Tests
	// --------------------
	initial
	begin
		sys_rst = 1'b1;
		req = '0;
		ev = '0;
		alu_f = 3'h5;
		tgt = 10'h155;
		pin = 1'b0;
		ps2 = 2'h0;
		lin = 2'h0;
		repeat (3) @(posedge mclk);
		sys_rst <= 1'b0;
		#1;
		chk(pc, PC_RST);
		chk(11'(st), 11'(STATUS_RST));
		chk(11'(role), 11'h003);
		acc(RD, ADR_TIMER, 8'h00);
		chk(11'(gd), 11'(BYTE_ZERO));
		acc(WR, ADR_TIMER, 8'hfe);
		fire(10'h100);
		chk(11'(tovf), 11'h000);
		fire(10'h100);
		chk(11'(tovf), 11'h001);
		acc(RD, ADR_TIMER, 8'h00);
		chk(11'(gd), 11'(BYTE_ZERO));
		$display("timer test done");
		// Status bits 3 and 4 must ignore the software write
		acc(WR, ADR_STATUS, 8'h60);
		acc(RD, ADR_STATUS, 8'h00);
		chk(11'(gd), 11'h078);
		fire(10'h002);
		chk(pc, {1'b1, tgt});
		fire(10'h004);
		chk(pc, VEC_GENERAL);
		fire(10'h008);
		chk(pc, VEC_USB);
		fire(10'h001);
		chk(pc, VEC_USB + PC_ONE);
		acc(WR, ADR_PC_LOW, 8'h33);
		chk(pc, 11'h433);
		$display("program counter test done");
		fire(10'h010);
		chk(11'(st), 11'h07d);
		fire(10'h040);
		chk(11'(st), 11'h075);
		fire(10'h080);
		chk(11'(st), 11'h065);
		fire(10'h020);
		chk(11'(st), 11'h07d);
		acc(WR, ADR_TIMER, 8'h42);
		fire(10'h040);
		fire(10'h200);
		chk(11'(st), 11'h010);
		chk(pc, PC_RST);
		acc(RD, ADR_TIMER, 8'h00);
		chk(11'(gd), 11'(BYTE_ZERO));
		$display("status test done");
		acc(WR, ADR_RAM_SEL, 8'ha5);
		acc(WR, ADR_INDIRECT, 8'h5a);
		acc(WR, ADR_RAM_SEL, 8'h65);
		acc(WR, ADR_INDIRECT, 8'hc3);
		acc(WR, ADR_RAM_SEL, 8'ha5);
		acc(RD, ADR_INDIRECT, 8'h00);
		chk(11'(gd), 11'h05a);
		acc(WR, ADR_RAM_SEL, 8'h1c);
		acc(WR, ADR_INDIRECT, 8'h77);
		acc(WR, ADR_RAM_SEL, 8'hdc);
		acc(RD, ADR_INDIRECT, 8'h00);
		chk(11'(gd), 11'h077);
		acc(RD, 6'h1c, 8'h00);
		chk(11'(gd), 11'h077);
		$display("ram test done");
		for (int b = 0; b < 2; b++)
		begin
			acc(WR, ADR_STATUS, {b[0], 7'h00});
			for (int c = 0; c < 2; c++)
				for (int a = 0; a < 16; a++)
				begin
					acc(c == 1 ? CRD : RD, 6'(a), 8'h00);
					s = a >= 5 && (c == 1 || b == 1 || a != 15);
					ex = {1'b1, s, s, s & b[0] & (a >= 8), 4'(a) & {4{s}}};
					gt = {gv, gx, ge.stb, ge.bank1 & ge.stb, ge.addr & {4{ge.stb}}};
					chk(11'(gt), 11'(ex));
				end
		end
		acc(CWR, ADR_STATUS, 8'hff);
		acc(RD, ADR_STATUS, 8'h00);
		chk(11'(gd), 11'h090);
		acc(RD, 6'h1c, 8'h00);
		chk(11'({gx, ge.stb, gd}), 11'h077);
		acc(CWR, 6'h08, 8'h3c);
		chk(11'({ge.wr, ge.ctl, ge.bank1, ge.wdata}), 11'h73c);
		chk(11'(ge.stb), 11'h001);
		$display("decode test done");
		@(posedge mclk);
		ps2 <= 2'h1;
		repeat (2) @(posedge mclk);
		#1;
		chk(11'(role), 11'h002);
		@(posedge mclk);
		lin <= 2'h3;
		pin <= 1'b1;
		irq = 2'h0;
		repeat (3)
		begin
			@(posedge mclk);
			#1;
			irq = irq | lirq;
		end
		chk(11'(irq), 11'h001);
		chk(11'(pser), 11'h001);
		@(posedge mclk);
		pin <= 1'b0;
		repeat (2) @(posedge mclk);
		#1;
		chk(11'(pser), 11'h000);
		$display("pin test done");
		report_and_stop();
	end
endmodule : tb_csr_core_regs
